// >>> src/dpt_delay.sv
// Tick-counting delay: done while enabled for at least the limit
`timescale 1ns/1ps
`default_nettype none
module dpt_delay (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Control
  input wire logic en_i,
  input wire logic tick_i,
  input wire logic [15:0] limit_i,
  output logic done_o
);

  typedef struct packed {
    logic [15:0] cnt;
  } dpt_delay_s;

  dpt_delay_s st_q;
  dpt_delay_s st_d;

  // Count ticks while enabled, restart when disabled
  always_comb begin
    st_d = st_q;
    if (!en_i) begin
      st_d.cnt = '0;
    end else if (tick_i && st_q.cnt <= limit_i) begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // A partial first tick is not counted, so the delay is never short
  assign done_o = en_i && (limit_i == 16'h0000 || st_q.cnt > limit_i);

endmodule : dpt_delay
`default_nettype wire

// >>> src/dpt_pkg.sv
// Shared constants for the drive protection trip logic
package dpt_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned FAN_LIFE_HOURS = 50_000;
  // Running ticks per 0.1 percent of the fan lifetime
  localparam int unsigned FAN_SLICE_TICKS = FAN_LIFE_HOURS * 3600 / 1000 * 1000 / TICK_MS;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RELAY1_FN = 8'h04;
  localparam logic [7:0] ADDR_RELAY2_FN = 8'h08;
  localparam logic [7:0] ADDR_UV_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_TERM_FN0 = 8'h10;
  localparam logic [7:0] ADDR_FAN_THRESH = 8'h24;
  localparam logic [7:0] ADDR_FAN_USAGE = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2C;
  localparam logic [7:0] ADDR_HOLD_FREQ = 8'h30;
  localparam logic [7:0] ADDR_HOLD_CUR = 8'h34;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h38;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h3C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h40;
  localparam logic [7:0] ADDR_CMD = 8'h44;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned NUM_TERM = 5;
  localparam int unsigned CMD_RUN_BIT = 0;
  localparam int unsigned CMD_RESET_BIT = 1;
  localparam int unsigned CMD_FAN_CLR_BIT = 2;
  localparam logic [15:0] UV_DELAY_RST = 16'h0000;
  localparam logic [15:0] UV_DELAY_MAX = 16'h0258;
  localparam logic [15:0] FAN_THRESH_RST = 16'h0384;
  localparam logic [15:0] FAN_THRESH_MAX = 16'h03E8;
  localparam logic [15:0] FAN_USAGE_MAX = 16'hFFFF;

  // ****************************************
  // Function codes
  // ****************************************
  localparam logic [7:0] FN_FAN_WARN = 8'h08;
  localparam logic [7:0] FN_LOW_VOLT = 8'h0B;
  localparam logic [7:0] FN_FAN_EXCH = 8'h25;
  localparam logic [7:0] FN_TERM_RESET = 8'h03;
  localparam logic [7:0] FN_TERM_BLOCK = 8'h05;

  // ****************************************
  // Keypad indication codes and events
  // ****************************************
  localparam logic [2:0] DISP_NONE = 3'h0;
  localparam logic [2:0] DISP_FAN_TRIP = 3'h1;
  localparam logic [2:0] DISP_HEAT_TRIP = 3'h2;
  localparam logic [2:0] DISP_LV_TRIP = 3'h3;
  localparam logic [2:0] DISP_BLOCK = 3'h4;
  localparam logic [2:0] DISP_FAN_EXCH = 3'h5;
  localparam int unsigned NUM_EVT = 6;

endpackage : dpt_pkg

// >>> src/dpt_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dpt_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } dpt_sync_s;

  dpt_sync_s st_q;
  dpt_sync_s st_d;

  // Shift chain; output follows once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.out[i] = st_q.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_o = st_q.out;

endmodule : dpt_sync
`default_nettype wire

// >>> src/dpt_top.sv
// Drive protection and trip handling with register port
//
// Contract
// - Fan error in trip mode blocks output and shows fan trip.
// - Fan error in warning mode drives relays set to function 8; run continues.
// - Overheat blocks output even in fan warning mode.
// - Fan running time accumulates in 0.1 percent of 50000 hours, to 6553.5.
// - Usage at exchange level raises keypad warning and function 37 relays.
// - Writing the fan clear command zeroes accumulated usage.
// - DC link undervoltage stops output and leads to low voltage trip.
// - Undervoltage blocks at once; trip registers after 0 to 60 s delay.
// - Function 11 relays show undervoltage at once, without the delay.
// - Terminal with function 5 on during run blocks output, shows block.
// - Frequency and current at block onset stay readable while blocked.
// - Resume needs block input off and a fresh run command.
// - Keypad reset or function 3 terminal clears trips.
`timescale 1ns/1ps
`default_nettype none
module dpt_top
  import dpt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned FAN_SLICE = FAN_SLICE_TICKS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Pins from power stage, fan and terminals
  input wire logic fan_err_i,
  input wire logic overheat_i,
  input wire logic dc_undervolt_i,
  input wire logic keypad_reset_i,
  input wire logic [NUM_TERM-1:0] term_i,
  // Running values from the control core
  input wire logic [15:0] op_freq_i,
  input wire logic [15:0] op_cur_i,
  // Outputs
  output logic gate_block_o,
  output logic relay1_o,
  output logic relay2_o,
  output logic [2:0] disp_code_o,
  output logic irq_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic fan_warn_mode;
    logic [7:0] relay1_fn;
    logic [7:0] relay2_fn;
    logic [15:0] uv_delay;
    logic [NUM_TERM-1:0][7:0] term_fn;
    logic [15:0] fan_thresh;
    logic [15:0] fan_usage;
    logic [31:0] tick_cnt;
    logic [31:0] slice_cnt;
    logic run;
    logic fan_trip;
    logic heat_trip;
    logic lv_trip;
    logic blk_prev;
    logic rst_prev;
    logic [15:0] hold_freq;
    logic [15:0] hold_cur;
    logic [NUM_EVT-1:0] irq_stat;
    logic [NUM_EVT-1:0] irq_en;
    logic fan_warn_prev;
    logic exch_prev;
    logic [31:0] rdata;
    logic gate_block;
    logic relay1;
    logic relay2;
    logic [2:0] disp;
    logic irq;
  } dpt_top_s;

  dpt_top_s st_q;
  dpt_top_s st_d;

  // ****************************************
  // Pin synchronisers and delay timer
  // ****************************************
  // Pin bit order: fan, heat, undervoltage, keypad, then terminals
  logic [NUM_TERM+3:0] pins_sync;
  logic fan_err;
  logic overheat;
  logic undervolt;
  logic key_reset;
  logic [NUM_TERM-1:0] term;
  logic tick;
  logic uv_done;

  dpt_sync #(
    .W(NUM_TERM + 4)
  ) u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .async_i({term_i, keypad_reset_i, dc_undervolt_i, overheat_i, fan_err_i}),
    .sync_o(pins_sync)
  );

  // Synchronised pin levels and the 0.1 s base tick
  assign fan_err = pins_sync[0];
  assign overheat = pins_sync[1];
  assign undervolt = pins_sync[2];
  assign key_reset = pins_sync[3];
  assign term = pins_sync[NUM_TERM+3:4];
  assign tick = (st_q.tick_cnt == TICK_CYCLES - 1);

  // Decision delay counted in 0.1 s ticks while undervoltage lasts
  dpt_delay u_uv_delay (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .en_i(undervolt),
    .tick_i(tick),
    .limit_i(st_q.uv_delay),
    .done_o(uv_done)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  // Decoded conditions of the current cycle
  logic blk_in;
  logic rst_in;
  logic rst_req;
  logic any_trip;
  logic fan_warn;
  logic exch_warn;
  logic blocked;
  logic [NUM_EVT-1:0] evt;
  logic [NUM_EVT-1:0] clr;

  // Function decode of the input terminals
  always_comb begin
    blk_in = 1'b0;
    rst_in = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (term[i] && st_q.term_fn[i] == FN_TERM_BLOCK) begin
        blk_in = 1'b1;
      end
      if (term[i] && st_q.term_fn[i] == FN_TERM_RESET) begin
        rst_in = 1'b1;
      end
    end
  end

  // Conditions feeding trips and relays
  always_comb begin
    // Keypad and terminal reset act on a rising edge only; a held key does not keep clearing
    rst_req = (key_reset && !st_q.rst_prev) || (rst_in && !st_q.rst_prev);
    if (wr_i && addr_i == ADDR_CMD && wdata_i[CMD_RESET_BIT]) begin
      rst_req = 1'b1;
    end
    any_trip = st_q.fan_trip || st_q.heat_trip || st_q.lv_trip;
    fan_warn = fan_err && st_q.fan_warn_mode;
    exch_warn = (st_q.fan_usage >= st_q.fan_thresh);
    blocked = any_trip || blk_in || undervolt;
  end

  always_comb begin
    st_d = st_q;
    evt = '0;
    clr = '0;
    st_d.rdata = '0;
    st_d.rst_prev = key_reset || rst_in;
    st_d.blk_prev = blk_in;
    st_d.fan_warn_prev = fan_warn;
    st_d.exch_prev = exch_warn;

    // Base tick divider
    if (tick) begin
      st_d.tick_cnt = '0;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 32'h0000_0001;
    end

    // Register writes
    if (wr_i) begin
      if (addr_i == ADDR_CTRL) begin
        st_d.fan_warn_mode = wdata_i[0];
      end else if (addr_i == ADDR_RELAY1_FN) begin
        st_d.relay1_fn = wdata_i[7:0];
      end else if (addr_i == ADDR_RELAY2_FN) begin
        st_d.relay2_fn = wdata_i[7:0];
      end else if (addr_i == ADDR_UV_DELAY) begin
        st_d.uv_delay = (wdata_i[15:0] > UV_DELAY_MAX) ? UV_DELAY_MAX : wdata_i[15:0];
      end else if (addr_i >= ADDR_TERM_FN0 && addr_i < ADDR_FAN_THRESH) begin
        st_d.term_fn[3'((addr_i - ADDR_TERM_FN0) >> 2)] = wdata_i[7:0];
      end else if (addr_i == ADDR_FAN_THRESH) begin
        st_d.fan_thresh = (wdata_i[15:0] > FAN_THRESH_MAX) ? FAN_THRESH_MAX : wdata_i[15:0];
      end else if (addr_i == ADDR_IRQ_CLR) begin
        clr = wdata_i[NUM_EVT-1:0];
      end else if (addr_i == ADDR_IRQ_EN) begin
        st_d.irq_en = wdata_i[NUM_EVT-1:0];
      end else if (addr_i == ADDR_CMD) begin
        if (wdata_i[CMD_RUN_BIT] && !blocked) begin
          st_d.run = 1'b1;
        end
      end
    end

    // Fan usage accumulator, counts while the fan runs
    if (wr_i && addr_i == ADDR_CMD && wdata_i[CMD_FAN_CLR_BIT]) begin
      st_d.fan_usage = '0;
      st_d.slice_cnt = '0;
    end else if (tick && st_q.run && !blocked) begin
      if (st_q.slice_cnt == FAN_SLICE - 1) begin
        st_d.slice_cnt = '0;
        if (st_q.fan_usage != FAN_USAGE_MAX) begin
          st_d.fan_usage = st_q.fan_usage + 16'h0001;
        end
      end else begin
        st_d.slice_cnt = st_q.slice_cnt + 32'h0000_0001;
      end
    end

    // Trip latches; reset first, a live cause sets again
    if (rst_req) begin
      st_d.fan_trip = 1'b0;
      st_d.heat_trip = 1'b0;
      st_d.lv_trip = 1'b0;
    end
    if (fan_err && !st_q.fan_warn_mode) begin
      st_d.fan_trip = 1'b1;
      evt[0] = !st_q.fan_trip;
    end
    if (overheat) begin
      st_d.heat_trip = 1'b1;
      evt[1] = !st_q.heat_trip;
    end
    if (uv_done) begin
      st_d.lv_trip = 1'b1;
      evt[2] = !st_q.lv_trip;
    end

    // Output block input: capture running values at onset
    if (blk_in && !st_q.blk_prev && st_q.run) begin
      st_d.hold_freq = op_freq_i;
      st_d.hold_cur = op_cur_i;
      evt[3] = 1'b1;
    end
    evt[4] = fan_warn && !st_q.fan_warn_prev;
    evt[5] = exch_warn && !st_q.exch_prev;

    // Any block drops the run state; a new run command is needed
    if (blocked) begin
      st_d.run = 1'b0;
    end

    // Sticky status, set wins over clear
    st_d.irq_stat = (st_q.irq_stat & ~clr) | evt;

    // Register reads, answered in the next cycle
    if (rd_i) begin
      if (addr_i == ADDR_CTRL) begin
        st_d.rdata = {31'h0, st_q.fan_warn_mode};
      end else if (addr_i == ADDR_RELAY1_FN) begin
        st_d.rdata = {24'h0, st_q.relay1_fn};
      end else if (addr_i == ADDR_RELAY2_FN) begin
        st_d.rdata = {24'h0, st_q.relay2_fn};
      end else if (addr_i == ADDR_UV_DELAY) begin
        st_d.rdata = {16'h0, st_q.uv_delay};
      end else if (addr_i >= ADDR_TERM_FN0 && addr_i < ADDR_FAN_THRESH) begin
        st_d.rdata = {24'h0, st_q.term_fn[3'((addr_i - ADDR_TERM_FN0) >> 2)]};
      end else if (addr_i == ADDR_FAN_THRESH) begin
        st_d.rdata = {16'h0, st_q.fan_thresh};
      end else if (addr_i == ADDR_FAN_USAGE) begin
        st_d.rdata = {16'h0, st_q.fan_usage};
      end else if (addr_i == ADDR_STATUS) begin
        st_d.rdata = {22'h0, exch_warn, fan_warn, undervolt, blk_in,
                      st_q.lv_trip, st_q.heat_trip, st_q.fan_trip, st_q.gate_block,
                      st_q.run, 1'b0};
      end else if (addr_i == ADDR_HOLD_FREQ) begin
        st_d.rdata = {16'h0, st_q.hold_freq};
      end else if (addr_i == ADDR_HOLD_CUR) begin
        st_d.rdata = {16'h0, st_q.hold_cur};
      end else if (addr_i == ADDR_IRQ_STAT) begin
        st_d.rdata = {{(32 - NUM_EVT){1'b0}}, st_q.irq_stat};
      end else if (addr_i == ADDR_IRQ_EN) begin
        st_d.rdata = {{(32 - NUM_EVT){1'b0}}, st_q.irq_en};
      end
    end

    // Registered outputs
    st_d.gate_block = !st_d.run || blocked;
    st_d.relay1 = (st_q.relay1_fn == FN_FAN_WARN && fan_warn)
               || (st_q.relay1_fn == FN_LOW_VOLT && undervolt)
               || (st_q.relay1_fn == FN_FAN_EXCH && exch_warn);
    st_d.relay2 = (st_q.relay2_fn == FN_FAN_WARN && fan_warn)
               || (st_q.relay2_fn == FN_LOW_VOLT && undervolt)
               || (st_q.relay2_fn == FN_FAN_EXCH && exch_warn);
    // Keypad indication, fan trip first, exchange warning last
    if (st_d.fan_trip) begin
      st_d.disp = DISP_FAN_TRIP;
    end else if (st_d.heat_trip) begin
      st_d.disp = DISP_HEAT_TRIP;
    end else if (st_d.lv_trip) begin
      st_d.disp = DISP_LV_TRIP;
    end else if (blk_in) begin
      st_d.disp = DISP_BLOCK;
    end else if (exch_warn) begin
      st_d.disp = DISP_FAN_EXCH;
    end else begin
      st_d.disp = DISP_NONE;
    end
    // Level interrupt from enabled sticky bits
    st_d.irq = |(st_d.irq_stat & st_d.irq_en);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_q <= '0;
      st_q.uv_delay <= UV_DELAY_RST;
      st_q.fan_thresh <= FAN_THRESH_RST;
      st_q.gate_block <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign rdata_o = st_q.rdata;
  assign gate_block_o = st_q.gate_block;
  assign relay1_o = st_q.relay1;
  assign relay2_o = st_q.relay2;
  assign disp_code_o = st_q.disp;
  assign irq_o = st_q.irq;

endmodule : dpt_top
`default_nettype wire

// >>> test/dpt_plant.sv
// Far-side model: fan, heat sensor, DC link, keypad, terminals, core values
`timescale 1ns/1ps
`default_nettype none
module dpt_plant (
  // Clock and commands from the bench
  input wire logic mclk_i,
  input wire logic [3:0] flt_i,
  input wire logic [4:0] tset_i,
  input wire logic [15:0] fset_i,
  // Pins towards the block
  output logic fan_err_o = 1'b0,
  output logic overheat_o = 1'b0,
  output logic dc_undervolt_o = 1'b0,
  output logic keypad_reset_o = 1'b0,
  output logic [4:0] term_o = 5'h00,
  output logic [15:0] op_freq_o = 16'h0000,
  output logic [15:0] op_cur_o = 16'h0000
);
  // Pins change only after a clock edge, as real contacts seen by the core
  always @(posedge mclk_i) begin
    {keypad_reset_o, dc_undervolt_o, overheat_o, fan_err_o} <= flt_i;
    term_o <= tset_i;
    op_freq_o <= fset_i;
    op_cur_o <= {1'b0, fset_i[15:1]};
  end
endmodule : dpt_plant
`default_nettype wire

// >>> test/dpt_top_sva.sv
// Port-level checker for the drive protection trip logic
`timescale 1ns/1ps
`default_nettype none
module dpt_top_sva
  import dpt_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned FAN_SLICE = FAN_SLICE_TICKS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Watched ports
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic overheat_i,
  input wire logic dc_undervolt_i,
  input wire logic gate_block_o,
  input wire logic [2:0] disp_code_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic [1:0] since_run_q;
  logic heat_shown;
  // Indication that an overheat may legally leave on the keypad
  assign heat_shown = (disp_code_o == DISP_FAN_TRIP) || (disp_code_o == DISP_HEAT_TRIP);
  // Cycles since the last run command, saturating
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      since_run_q <= 2'h3;
    end else if (wr_i && addr_i == ADDR_CMD && wdata_i[CMD_RUN_BIT]) begin
      since_run_q <= 2'h0;
    end else if (since_run_q != 2'h3) begin
      since_run_q <= since_run_q + 2'h1;
    end
  end
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside read answer cycle");
  chk_uv_block: assert property (dc_undervolt_i [*8] |-> gate_block_o)
    else $error("undervoltage did not block output");
  chk_heat_block: assert property (overheat_i [*8] |-> gate_block_o)
    else $error("overheat did not block output");
  chk_heat_disp: assert property (overheat_i [*8] |-> heat_shown)
    else $error("overheat trip not shown");
  chk_fan_trip_blk: assert property (disp_code_o == DISP_FAN_TRIP |-> ##[0:1] gate_block_o)
    else $error("fan trip shown without block");
  chk_lv_trip_blk: assert property (disp_code_o == DISP_LV_TRIP |-> ##[0:1] gate_block_o)
    else $error("low voltage trip shown without block");
  chk_bx_blk: assert property (disp_code_o == DISP_BLOCK |-> ##[0:1] gate_block_o)
    else $error("output block shown without block");
  chk_resume_cmd: assert property ($fell(gate_block_o) |-> since_run_q <= 2'h2)
    else $error("output resumed without run command");
  cover property (gate_block_o ##1 !gate_block_o);
  cover property (disp_code_o == DISP_LV_TRIP);
  cover property (disp_code_o == DISP_FAN_EXCH);
endmodule : dpt_top_sva
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the drive protection trip logic
`timescale 1ns/1ps
`default_nettype none
module tb
  import dpt_pkg::*;
;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d1 = 1'b0;
  logic [3:0] flt = 4'h0;
  logic [4:0] tset = 5'h00;
  logic [15:0] fset = 16'h0000;
  logic [15:0] seed = 16'h0051;
  logic [15:0] f;
  logic [31:0] rdata;
  logic fan_err, hot, uv, key, gblk, rel1, rel2, irq;
  logic [4:0] term;
  logic [15:0] freq, cur;
  logic [2:0] disp;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int check_count = 0;
  // Output masks: irq, relay2, relay1, block, indication
  localparam logic [7:0] I = 8'h80, R2 = 8'h40, R1 = 8'h20, G = 8'h10, D = 8'h07;

  always #50 mclk_i = ~mclk_i;

  dpt_plant u_plant (.mclk_i(mclk_i), .flt_i(flt), .tset_i(tset), .fset_i(fset),
    .fan_err_o(fan_err), .overheat_o(hot), .dc_undervolt_o(uv), .keypad_reset_o(key),
    .term_o(term), .op_freq_o(freq), .op_cur_o(cur));
  dpt_top #(.TICK_CYCLES(10), .FAN_SLICE(3)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .fan_err_i(fan_err), .overheat_i(hot), .dc_undervolt_i(uv), .keypad_reset_i(key),
    .term_i(term), .op_freq_i(freq), .op_cur_i(cur), .gate_block_o(gblk),
    .relay1_o(rel1), .relay2_o(rel2), .disp_code_o(disp), .irq_o(irq));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction : xs

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t read got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_rd

  // Settle, then compare the masked outputs
  task automatic see(input logic [7:0] m, input logic [7:0] e);
    logic [7:0] o;
    repeat (10) @(posedge mclk_i);
    @(negedge mclk_i);
    o = {irq, rel2, rel1, gblk, 1'b0, disp};
    check_count++;
    if ((o & m) !== (e & m)) begin
      n_fail++;
      $display("[FAIL] t=%0t pins got=%h exp=%h", $time, o & m, e & m);
    end
  endtask : see

  // One write, or one read noting its expected answer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr <= w;
    rd <= ~w;
    addr <= a;
    wdata <= d;
    if (!w) exp_q.push_back(d);
    @(posedge mclk_i);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic pins(input logic [3:0] fl, input logic [4:0] t);
    @(posedge mclk_i);
    flt <= fl;
    tset <= t;
  endtask : pins

  task automatic complete_run();
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Read answers are compared in the cycle after the strobe
  always @(posedge mclk_i) rd_d1 <= rd;
  always @(negedge mclk_i) begin
    if (rd_d1 && exp_q.size() > 0) chk_rd(rdata, exp_q.pop_front());
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    see(I | R2 | R1 | G | D, G);
    bus(0, ADDR_UV_DELAY, 32'h0);
    bus(0, ADDR_FAN_THRESH, 32'h384);
    bus(0, 8'h48, 32'h0);
    bus(1, ADDR_IRQ_EN, 32'h3F);
    bus(1, ADDR_RELAY1_FN, {24'h0, FN_FAN_WARN});
    bus(1, ADDR_RELAY2_FN, {24'h0, FN_LOW_VOLT});
    bus(1, ADDR_TERM_FN0, {24'h0, FN_TERM_BLOCK});
    bus(1, ADDR_TERM_FN0 + 8'h04, {24'h0, FN_TERM_RESET});
    f = xs();
    fset <= f;
    bus(1, ADDR_CMD, 32'h1);
    see(I | G, 8'h00);
    // Output block input during run
    pins(4'h0, 5'h01);
    see(I | G | D, 8'h94);
    bus(0, ADDR_HOLD_FREQ, {16'h0, f});
    bus(0, ADDR_HOLD_CUR, {17'h0, f[15:1]});
    bus(0, ADDR_IRQ_STAT, 32'h8);
    pins(4'h0, 5'h00);
    see(G, G);
    bus(1, ADDR_IRQ_CLR, 32'h3F);
    bus(1, ADDR_CMD, 32'h1);
    see(I | G, 8'h00);
    // Fan error in warning mode, then in trip mode
    bus(1, ADDR_CTRL, 32'h1);
    pins(4'h1, 5'h00);
    see(G | R1, R1);
    pins(4'h0, 5'h00);
    bus(1, ADDR_CTRL, 32'h0);
    pins(4'h1, 5'h00);
    see(G | D, 8'h11);
    pins(4'h0, 5'h00);
    see(G | D, 8'h11);
    bus(0, ADDR_STATUS, 32'hC);
    pins(4'h0, 5'h02);
    see(G | D, 8'h10);
    pins(4'h0, 5'h00);
    bus(1, ADDR_CMD, 32'h1);
    // Overheat while in fan warning mode, cleared from the keypad
    bus(1, ADDR_CTRL, 32'h1);
    pins(4'h2, 5'h00);
    see(G | D, 8'h12);
    pins(4'h0, 5'h00);
    see(G | D, 8'h12);
    pins(4'h8, 5'h00);
    see(D, 8'h00);
    pins(4'h0, 5'h00);
    bus(1, ADDR_CMD, 32'h1);
    // Undervoltage with a three-tick decision delay
    bus(1, ADDR_UV_DELAY, 32'hFFFF);
    bus(0, ADDR_UV_DELAY, {16'h0, UV_DELAY_MAX});
    bus(1, ADDR_UV_DELAY, 32'h3);
    pins(4'h4, 5'h00);
    see(G | R2 | D, 8'h50);
    repeat (60) @(posedge mclk_i);
    see(G | D, 8'h13);
    pins(4'h0, 5'h00);
    see(R2 | G | D, 8'h13);
    bus(1, ADDR_CMD, 32'h2);
    bus(1, ADDR_CMD, 32'h1);
    see(G | D, 8'h00);
    // Fan lifetime with masked interrupt, then usage clear
    bus(1, ADDR_IRQ_CLR, 32'h3F);
    bus(1, ADDR_IRQ_EN, 32'h0);
    bus(1, ADDR_RELAY2_FN, {24'h0, FN_FAN_EXCH});
    bus(1, ADDR_FAN_THRESH, 32'hFFFF);
    bus(0, ADDR_FAN_THRESH, {16'h0, FAN_THRESH_MAX});
    bus(1, ADDR_FAN_THRESH, 32'h1);
    see(I | R2 | D, 8'h45);
    pins(4'h0, 5'h01);
    see(I | G | D, 8'h14);
    bus(1, ADDR_CMD, 32'h4);
    bus(0, ADDR_FAN_USAGE, 32'h0);
    see(R2, 8'h00);
    complete_run();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_fail++;
    complete_run();
  end
endmodule : tb

bind dpt_top dpt_top_sva #(.TICK_CYCLES(TICK_CYCLES), .FAN_SLICE(FAN_SLICE)) u_sva (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .overheat_i(overheat_i), .dc_undervolt_i(dc_undervolt_i),
  .gate_block_o(gate_block_o), .disp_code_o(disp_code_o));
`default_nettype wire
